// ### usm_pkg.sv
/*
 * usm_pkg: register map, field positions, reset values, modes and
 * carrier structs for the synchronous master serial port.
 * Assumes the register port decodes a 6-bit address in which bit 5
 * selects the upper register bank.
 */
package usm_pkg;

    localparam int USM_ADDR_W = 6;
    localparam int USM_DIV_W = 8;
    localparam int USM_FIFO_DEPTH = 2;

    localparam logic [5:0] ADDR_RX_CTL = 6'h13;
    localparam logic [5:0] ADDR_RX_FIFO = 6'h14;
    localparam logic [5:0] ADDR_TX_CTL = 6'h15;
    localparam logic [5:0] ADDR_TX_BUF = 6'h16;
    localparam logic [5:0] ADDR_RATE = 6'h17;
    localparam logic [5:0] ADDR_FLAG = 6'h36;
    localparam logic [5:0] ADDR_ENABLE = 6'h37;

    // rx_control_status fields
    localparam int RX_PORT_ON = 7;
    localparam int RX_NINE_SEL = 6;
    localparam int RX_SINGLE = 5;
    localparam int RX_CONT = 4;
    localparam int RX_FRAMING = 2;
    localparam int RX_OVERRUN = 1;
    localparam int RX_NINTH = 0;
    // tx_control_status fields
    localparam int TX_CLK_MASTER = 7;
    localparam int TX_NINE_SEL = 6;
    localparam int TX_ENABLE = 5;
    localparam int TX_SYNC_MODE = 4;
    localparam int TX_SHIFT_EMPTY = 1;
    localparam int TX_NINTH = 0;
    // flag / enable fields
    localparam int FLAG_TX = 1;
    localparam int FLAG_RX = 0;

    localparam logic [7:0] RX_CTL_RST = 8'h00;
    localparam logic [7:0] TX_CTL_RST = 8'h02;
    localparam logic [7:0] FLAG_RST = 8'h02;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] RATE_RST = 8'h00;

    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;

    typedef enum logic [1:0] {
        USM_IDLE = 2'b00,
        USM_TX = 2'b01,
        USM_RX = 2'b11
    } usm_mode_t;

    typedef struct packed {
        logic [USM_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } usm_bus_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic ninth;
        logic framing;
    } usm_rx_word_t;

    typedef struct packed {
        logic port_on;
        logic nine_rx;
        logic single_rx;
        logic cont_rx;
        logic overrun;
        logic clk_master;
        logic nine_tx;
        logic tx_en;
        logic sync_mode;
        logic tx_ninth;
        logic [7:0] tx_buf;
        logic buf_full;
        logic [8:0] tx_sh;
        logic tx_busy;
        logic tx_nine;
        logic [3:0] tx_cnt;
        logic [8:0] rx_sh;
        logic [3:0] rx_cnt;
        usm_rx_word_t [USM_FIFO_DEPTH-1:0] fifo;
        logic [1:0] fifo_cnt;
        logic rd_ptr;
        logic ie_tx;
        logic ie_rx;
        logic [7:0] rate;
        logic ck;
        logic dout;
        usm_mode_t mode;
        logic din_s1;
        logic din_s2;
        logic [7:0] rdata;
    } usm_state_t;

    typedef struct packed {
        logic [USM_DIV_W-1:0] cnt;
        logic tick;
    } usm_rate_state_t;

endpackage

// ### usm_rate_gen.sv
/*
 * usm_rate_gen: divider that pulses tick once every divisor+1 cycles.
 * Assumes hold is a same-clock level; while it is high the count
 * stays at zero and no tick is produced.
 */
`timescale 1ns/1ps
module usm_rate_gen import usm_pkg::*; #(
    parameter int W = USM_DIV_W
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic hold,
    input wire logic [W-1:0] divisor,
    output logic tick
);

    usm_rate_state_t q, d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (hold) begin
            d.cnt = '0;
        end else if (q.cnt >= divisor) begin
            d.cnt = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

endmodule

// ### usm_sync_master.sv
/*
 * usm_sync_master: synchronous master serial port, half duplex, with
 * transmit buffer and shifter, receive shifter and two-word FIFO.
 * Assumes a one-cycle register port with read data one cycle later,
 * and an external pad that resolves the pin output enables.
 */
// The plain strobed port was decided locally.
// Overview of operation
// - shifter reloads from buffer only after its last bit is out
// - buffer moves to shifter on a rate tick; buffer-empty flag sets
// - buffer-empty flag sets regardless of enable; only a buffer write clears
// - transmit interrupt request gated by its enable bit
// - read-only shifter-empty flag shows idle shifter, no interrupt
// - transmit enable allows sending; nothing shifts until buffer loaded
// - data bits change on rising shift clock, stable at falling edge
// - rate generator held reset while transmit and both receive bits clear
// - clearing transmit enable aborts word; with no receive bit set it floats both pins
// - receive bits override transmit: data floats, clock stays driven
// - single receive clears itself after its word; transmit resumes
// - nine-bit transmit select; ninth bit captured at shifter load
// - port off or transmit enable clear resets the transmit logic
// - receive enabled by single or continuous bit, sampled on falling edge
// - single receives one word, continuous until cleared, continuous wins
// - finished word moves to FIFO if room, setting receive-ready flag
// - receive-ready flag read-only, clears when FIFO read empty
// - two-word FIFO; full at third word sets overrun, word discarded
// - overrun blocks FIFO writes until continuous receive is cleared
// - ninth bit and framing flag queue with data, advance on read
// - port off or both receive bits clear resets receive logic
// - half duplex: transmit and receive exclude each other
// - sync mode, port enable and master clock bits gate the pins
`timescale 1ns/1ps
module usm_sync_master import usm_pkg::*; (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire usm_bus_req_t bus_req,
    output logic [7:0] rd_data,
    output logic clock_pin_o,
    output logic clock_pin_oe,
    input wire logic data_pin_i,
    output logic data_pin_o,
    output logic data_pin_oe,
    output logic tx_irq,
    output logic rx_irq
);

    usm_state_t q, d;
    logic tick;
    logic master;
    logic rx_en;
    logic brg_hold;
    logic rise;
    logic fall;
    logic tx_reset;
    logic rx_reset;
    logic [3:0] tx_last;
    logic [3:0] rx_last;
    logic rx_word_done;
    logic tx_word_done;
    logic fifo_full;
    logic wr_buf;
    usm_rx_word_t head;

    assign master = q.port_on & q.sync_mode & q.clk_master;
    assign rx_en = master & (q.single_rx | q.cont_rx);
    assign brg_hold = !(q.port_on & (q.tx_en | q.single_rx | q.cont_rx));
    assign rise = tick & !q.ck;
    assign fall = tick & q.ck;
    assign tx_reset = !q.port_on | !q.tx_en;
    assign rx_reset = !q.port_on | !(q.single_rx | q.cont_rx);
    assign tx_last = q.tx_nine ? LAST_BIT_9 : LAST_BIT_8;
    assign rx_last = q.nine_rx ? LAST_BIT_9 : LAST_BIT_8;
    assign rx_word_done = !rx_reset && master && fall && q.rx_cnt == rx_last;
    // transmit engine is frozen, not reset, while receiving
    assign tx_word_done = !tx_reset && master && !rx_en && rise
                          && q.tx_busy && q.tx_cnt == tx_last;
    assign fifo_full = q.fifo_cnt == 2'(USM_FIFO_DEPTH);
    assign wr_buf = bus_req.wr && bus_req.addr == ADDR_TX_BUF;
    assign head = q.fifo[q.rd_ptr];

    usm_rate_gen #(
        .W(USM_DIV_W)
    ) u_rate (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .hold(brg_hold),
        .divisor(q.rate),
        .tick(tick)
    );

    always_comb begin
        logic [8:0] rx_new;
        logic push;
        logic pop;
        logic wr_idx;
        usm_rx_word_t push_word;
        rx_new = {q.din_s2, q.rx_sh[8:1]};
        push = 1'b0;
        pop = 1'b0;
        wr_idx = q.rd_ptr ^ (q.fifo_cnt == 2'd1);
        push_word = '0;
        d = q;
        d.din_s1 = data_pin_i;
        d.din_s2 = q.din_s1;
        d.rdata = 8'h00;

        // shift clock idles low whenever the generator is held
        if (brg_hold) begin
            d.ck = 1'b0;
        end else if (tick) begin
            d.ck = !q.ck;
        end

        // transmit engine
        if (tx_reset) begin
            d.tx_busy = 1'b0;
            d.tx_cnt = 4'h0;
        end else if (master && !rx_en && rise) begin
            if (q.tx_busy && q.tx_cnt != tx_last) begin
                d.tx_sh = {1'b0, q.tx_sh[8:1]};
                d.tx_cnt = q.tx_cnt + 4'h1;
                d.dout = q.tx_sh[1];
            end else if (q.buf_full) begin
                // ninth bit latched now, so it must be written first
                d.tx_sh = {q.tx_ninth, q.tx_buf};
                d.tx_nine = q.nine_tx;
                d.tx_busy = 1'b1;
                d.tx_cnt = 4'h0;
                d.buf_full = 1'b0;
                d.dout = q.tx_buf[0];
            end else begin
                d.tx_busy = 1'b0;
            end
        end

        // receive engine
        if (rx_reset) begin
            d.rx_cnt = 4'h0;
        end else if (master && fall) begin
            d.rx_sh = rx_new;
            if (q.rx_cnt == rx_last) begin
                d.rx_cnt = 4'h0;
                if (!q.overrun) begin
                    if (fifo_full) begin
                        d.overrun = 1'b1;
                    end else begin
                        push = 1'b1;
                    end
                end
                if (!q.cont_rx) begin
                    d.single_rx = 1'b0;
                end
            end else begin
                d.rx_cnt = q.rx_cnt + 4'h1;
            end
        end
        // sync mode has no stop bit, so framing is always queued clear
        push_word.data = q.nine_rx ? rx_new[7:0] : rx_new[8:1];
        push_word.ninth = q.nine_rx ? rx_new[8] : 1'b0;
        push_word.framing = 1'b0;

        // register writes; a buffer write after a same-cycle load wins
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                ADDR_RX_CTL: begin
                    d.port_on = bus_req.wdata[RX_PORT_ON];
                    d.nine_rx = bus_req.wdata[RX_NINE_SEL];
                    d.single_rx = bus_req.wdata[RX_SINGLE];
                    d.cont_rx = bus_req.wdata[RX_CONT];
                    if (!bus_req.wdata[RX_CONT]) begin
                        d.overrun = 1'b0;
                    end
                end
                ADDR_TX_CTL: begin
                    d.clk_master = bus_req.wdata[TX_CLK_MASTER];
                    d.nine_tx = bus_req.wdata[TX_NINE_SEL];
                    d.tx_en = bus_req.wdata[TX_ENABLE];
                    d.sync_mode = bus_req.wdata[TX_SYNC_MODE];
                    d.tx_ninth = bus_req.wdata[TX_NINTH];
                end
                ADDR_TX_BUF: begin
                    d.tx_buf = bus_req.wdata;
                    d.buf_full = 1'b1;
                end
                ADDR_RATE: begin
                    d.rate = bus_req.wdata;
                end
                ADDR_ENABLE: begin
                    d.ie_tx = bus_req.wdata[FLAG_TX];
                    d.ie_rx = bus_req.wdata[FLAG_RX];
                end
                default: begin
                end
            endcase
        end

        // register reads; flag register ignores writes
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                ADDR_RX_CTL: begin
                    d.rdata = {q.port_on, q.nine_rx, q.single_rx, q.cont_rx,
                               1'b0, head.framing, q.overrun, head.ninth};
                end
                ADDR_RX_FIFO: begin
                    d.rdata = head.data;
                    pop = q.fifo_cnt != 2'd0;
                end
                ADDR_TX_CTL: begin
                    d.rdata = {q.clk_master, q.nine_tx, q.tx_en, q.sync_mode,
                               2'b00, !q.tx_busy, q.tx_ninth};
                end
                ADDR_TX_BUF: begin
                    d.rdata = q.tx_buf;
                end
                ADDR_RATE: begin
                    d.rdata = q.rate;
                end
                ADDR_FLAG: begin
                    d.rdata = {6'h00, !q.buf_full, q.fifo_cnt != 2'd0};
                end
                ADDR_ENABLE: begin
                    d.rdata = {6'h00, q.ie_tx, q.ie_rx};
                end
                default: begin
                    d.rdata = 8'h00;
                end
            endcase
        end

        // receive FIFO bookkeeping
        if (push) begin
            d.fifo[wr_idx] = push_word;
        end
        if (pop) begin
            d.rd_ptr = !q.rd_ptr;
        end
        if (push && !pop) begin
            d.fifo_cnt = q.fifo_cnt + 2'd1;
        end else if (pop && !push) begin
            d.fifo_cnt = q.fifo_cnt - 2'd1;
        end
        if (rx_reset) begin
            d.overrun = d.overrun & q.cont_rx;
        end

        // pin ownership
        if (!master) begin
            d.mode = USM_IDLE;
        end else if (rx_en) begin
            d.mode = USM_RX;
        end else if (q.tx_en) begin
            d.mode = USM_TX;
        end else begin
            d.mode = USM_IDLE;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
            q.buf_full <= ~FLAG_RST[FLAG_TX];
            q.rate <= RATE_RST;
            q.mode <= USM_IDLE;
        end else begin
            q <= d;
        end
    end

    assign rd_data = q.rdata;
    assign clock_pin_o = q.ck;
    assign clock_pin_oe = q.mode != USM_IDLE;
    assign data_pin_o = q.dout;
    assign data_pin_oe = q.mode == USM_TX;
    assign tx_irq = !q.buf_full & q.ie_tx;
    assign rx_irq = (q.fifo_cnt != 2'd0) & q.ie_rx;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    chk_no_early_reload: assert property (
        q.tx_busy && q.tx_cnt != tx_last |=> !$fell(q.buf_full))
        else $error("buffer emptied before last bit shifted");
    chk_load_on_tick: assert property (
        $fell(q.buf_full) |-> $past(tick) && q.tx_busy && q.tx_cnt == 4'h0)
        else $error("shifter load not aligned to rate tick");
    chk_flag_sticky: assert property (
        !q.buf_full && !wr_buf |=> !q.buf_full)
        else $error("buffer-empty flag cleared without buffer write");
    chk_tx_irq_gate: assert property (
        bus_req.wr && bus_req.addr == ADDR_ENABLE
        && !bus_req.wdata[FLAG_TX] |=> !tx_irq)
        else $error("transmit request not gated by enable");
    chk_empty_read: assert property (
        bus_req.rd && bus_req.addr == ADDR_TX_CTL
        |=> rd_data[TX_SHIFT_EMPTY] == !$past(q.tx_busy))
        else $error("shifter-empty flag misreported");
    chk_rate_held: assert property (
        brg_hold |=> !tick)
        else $error("rate tick while generator held");
    chk_pins_float: assert property (
        !q.tx_en && !rx_en |=> !data_pin_oe && !clock_pin_oe)
        else $error("pins driven with port disabled");
    chk_rx_owns_pins: assert property (
        rx_en |=> !data_pin_oe && clock_pin_oe)
        else $error("data pin driven during reception");
    chk_overrun_set: assert property (
        rx_word_done && fifo_full && !q.overrun |=> q.overrun)
        else $error("overrun not flagged on full fifo");
    chk_overrun_block: assert property (
        q.overrun |=> q.fifo_cnt <= $past(q.fifo_cnt))
        else $error("fifo written while overrun set");
    chk_single_ends: assert property (
        rx_word_done && !q.cont_rx
        && !(bus_req.wr && bus_req.addr == ADDR_RX_CTL) |=> !q.single_rx)
        else $error("single receive not cleared after word");
    chk_first_bit: assert property (
        $rose(q.tx_busy) |-> $rose(clock_pin_o)
        && data_pin_o == $past(q.tx_buf[0]))
        else $error("first bit not launched on rising shift clock");
    chk_ninth_load: assert property (
        $rose(q.tx_busy) |-> q.tx_sh[8] == $past(q.tx_ninth)
        && q.tx_nine == $past(q.nine_tx))
        else $error("ninth bit not taken at shifter load");
    chk_tx_frozen: assert property (
        rx_en && !tx_reset |=> $stable(q.tx_sh) && $stable(q.tx_cnt))
        else $error("transmit shifter moved during reception");
    chk_rx_push: assert property (
        rx_word_done && !fifo_full && !q.overrun |=> q.fifo_cnt != 2'd0)
        else $error("finished word not queued");
    chk_ready_holds: assert property (
        q.fifo_cnt != 2'd0 && !(bus_req.rd && bus_req.addr == ADDR_RX_FIFO)
        |=> q.fifo_cnt != 2'd0)
        else $error("receive-ready cleared without fifo read");

    cov_tx_word: cover property (tx_word_done);
    cov_rx_word: cover property (rx_word_done && !fifo_full);
    cov_overrun: cover property (rx_word_done && fifo_full);
    cov_resume_tx: cover property (
        q.mode == USM_RX && q.tx_en ##1 q.mode == USM_TX);

endmodule

// ### usm_periph_model.sv
/*
 * usm_periph_model: external synchronous peripheral on the clock and
 * data pins of the serial port.
 * Assumes the bench resolves the data wire from both enables and
 * pulses clr before each exchange.
 */
`timescale 1ns/1ps
module usm_periph_model (
    input wire logic clk_pin,
    input wire logic clk_oe,
    input wire logic dev_oe,
    input wire logic dev_dout,
    input wire logic clr,
    input wire logic nine,
    input wire logic [8:0] word,
    output logic dout,
    output logic drive,
    output logic [17:0] hist,
    output logic [5:0] nbits
);
    logic [3:0] idx;
    // drives only while clocked by the master with data released
    assign drive = clk_oe && !dev_oe;
    // device bits taken at the falling clock, lsb first
    always @(negedge clk_pin or posedge clr) begin
        if (clr) begin
            hist <= '0;
            nbits <= '0;
            idx <= '0;
        end else if (dev_oe) begin
            hist <= {dev_dout, hist[17:1]};
            nbits <= nbits + 6'h01;
        end else begin
            idx <= (idx == (nine ? 4'h8 : 4'h7)) ? 4'h0 : idx + 4'h1;
        end
    end
    // new bit after the rising clock, so it is settled at the fall
    always @(posedge clk_pin or posedge clr) begin
        if (clr)
            dout <= word[0];
        else
            dout <= word[idx];
    end
endmodule

// ### testbench.sv
/*
 * testbench: register table, transmit, receive and overrun checks
 * for the synchronous master serial port.
 * Assumes the far-side model in usm_periph_model and a 200 MHz clock.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
 $display("FAIL t=%0t got %h exp %h", $time, a, e); end end
`define WT(c) for (int i = 0; i < 4000 && !(c); i++) @(posedge sys_clk);
module testbench;
    import usm_pkg::*;
    typedef struct packed {
        logic w;
        logic [5:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } usm_row_t;
    logic sys_clk, arst_n, data_wire, last_q, mclr, mnine, mout, mdrv;
    logic clock_pin_o, clock_pin_oe, data_pin_o, data_pin_oe;
    logic tx_irq, rx_irq;
    logic [7:0] rd_data, v;
    logic [8:0] mword;
    logic [17:0] hist;
    logic [5:0] nb;
    usm_bus_req_t req;
    int num_errors, checks;
    usm_row_t rows[10] = '{
        '{1'b0, 6'h13, 8'h00, 8'h00}, '{1'b0, 6'h15, 8'h00, 8'h02},
        '{1'b0, 6'h36, 8'h00, 8'h02}, '{1'b0, 6'h37, 8'h00, 8'h00},
        '{1'b0, 6'h17, 8'h00, 8'h00}, '{1'b1, 6'h3f, 8'hff, 8'h00},
        '{1'b1, 6'h36, 8'h00, 8'h02}, '{1'b1, 6'h15, 8'hc1, 8'hc3},
        '{1'b1, 6'h37, 8'h03, 8'h03}, '{1'b1, 6'h17, 8'h5a, 8'h5a}};

    // released wire flips every cycle so a stale value cannot pass
    assign data_wire = data_pin_oe ? data_pin_o : (mdrv ? mout : ~last_q);
    // unknown counts as low so the flipping starts from a known level
    always @(posedge sys_clk) last_q <= (data_wire === 1'b1);

    usm_sync_master DUT (.sys_clk, .arst_n, .bus_req(req), .rd_data,
        .clock_pin_o, .clock_pin_oe, .data_pin_i(data_wire),
        .data_pin_o, .data_pin_oe, .tx_irq, .rx_irq);
    usm_periph_model peer (.clk_pin(clock_pin_o), .clk_oe(clock_pin_oe),
        .dev_oe(data_pin_oe), .dev_dout(data_pin_o), .clr(mclr),
        .nine(mnine), .word(mword), .dout(mout), .drive(mdrv),
        .hist(hist), .nbits(nb));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1;
        d = rd_data;
    endtask

    task automatic peer_clear();
        @(posedge sys_clk);
        mclr <= 1'b1;
        @(posedge sys_clk);
        mclr <= 1'b0;
    endtask

    task automatic done(input string name);
        $display("test %0s done", name);
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        req = '0;
        arst_n = 1'b0;
        mclr = 1'b0;
        mnine = 1'b1;
        mword = 9'h169;
        num_errors = 0;
        checks = 0;
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            `CHK(v, rows[i].e)
        end
        `CHK(tx_irq, 1'b1)
        `CHK(clock_pin_o, 1'b0)
        wr(6'h37, 8'h01);
        `CHK(tx_irq, 1'b0)
        done("registers");
        // load first, then enable: first word goes out at once
        wr(6'h37, 8'h03);
        wr(6'h13, 8'h80);
        wr(6'h17, 8'h01);
        wr(6'h15, 8'hd1);
        wr(6'h16, 8'ha5);
        `CHK(tx_irq, 1'b0)
        peer_clear();
        wr(6'h15, 8'hf1);
        `WT(tx_irq === 1'b1)
        `CHK(tx_irq, 1'b1)
        // ninth bit of the second word goes in before its data
        wr(6'h15, 8'hf0);
        wr(6'h16, 8'h3c);
        rd(6'h36, v);
        `CHK(v, 8'h00)
        `WT(nb == 6'd18)
        `CHK(hist, {1'b0, 8'h3c, 1'b1, 8'ha5})
        repeat (6) @(posedge sys_clk);
        rd(6'h15, v);
        `CHK(v, 8'hf2)
        wr(6'h15, 8'hd0);
        repeat (2) @(posedge sys_clk);
        `CHK({clock_pin_oe, data_pin_oe}, 2'b00)
        done("transmit");
        wr(6'h15, 8'h90);
        wr(6'h17, 8'h03);
        wr(6'h37, 8'h01);
        peer_clear();
        wr(6'h13, 8'he0);
        repeat (6) @(posedge sys_clk);
        `CHK({clock_pin_oe, data_pin_oe}, 2'b10)
        // transmit enabled mid-word: pins come back after the word
        wr(6'h15, 8'hb0);
        `WT(rx_irq === 1'b1)
        `CHK(rx_irq, 1'b1)
        rd(6'h13, v);
        `CHK(v, 8'hc1)
        `CHK(data_pin_oe, 1'b1)
        rd(6'h14, v);
        `CHK(v, 8'h69)
        `CHK(rx_irq, 1'b0)
        wr(6'h15, 8'h90);
        done("single receive");
        peer_clear();
        wr(6'h13, 8'hd0);
        repeat (300) @(posedge sys_clk);
        rd(6'h13, v);
        `CHK(v, 8'hd3)
        rd(6'h14, v);
        `CHK(v, 8'h69)
        rd(6'h14, v);
        `CHK(v, 8'h69)
        rd(6'h36, v);
        `CHK(v, 8'h02)
        wr(6'h13, 8'hc0);
        rd(6'h13, v);
        `CHK(v & 8'hfe, 8'hc0)
        done("overrun");
        wr(6'h13, 8'hd0);
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        `CHK({rd_data, clock_pin_o, clock_pin_oe, data_pin_oe}, 11'h000)
        arst_n <= 1'b1;
        rd(6'h13, v);
        `CHK(v, 8'h00)
        done("mid-run reset");
        final_report();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        final_report();
    end
endmodule
